// >>> design/i2cmr_master_rx.v
`include "i2cmr_defines.vh"
module i2cmr_master_rx #(
  parameter BAUD_W = 8
) (
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // bus pins (open drain, oe low = drive low)
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_n,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  // interrupt
  output reg irq
);
  // one-hot states
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_START = 7'h02;
  localparam [6:0] ST_ADDR = 7'h04;
  localparam [6:0] ST_RX = 7'h08;
  localparam [6:0] ST_ACK = 7'h10;
  localparam [6:0] ST_STOP = 7'h20;
  localparam [6:0] ST_HOLD = 7'h40;
  // idle: bus free, clock and data released
  // start: data pulled low, then clock pulled low
  // addr: eight address bits out, ninth clock samples ack
  // rx: eight clocks in, byte lands in the buffer
  // ack: one clock carrying the chosen ack value
  // stop: clock released, then data released
  // hold: clock held low, waiting for software
  // hold accepts the same commands as idle
  // each half of a bus clock is one baud rollover
  // phase_r low means the next rollover raises the clock
  // phase_r high means the next rollover drops the clock
  // received bits are taken just before the clock drops
  // so the slave has a whole high half to settle
  // clock stretching by the slave is not supported

  // decode offset match for a register access
  // used by the strobes, the error flag and the read mux
  // keeps every compare against the same 12-bit offset
  // unaligned offsets simply never match
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  reg [6:0] state_r; // sequencer state
  reg [BAUD_W-1:0] baud_r; // baud reload value
  reg [BAUD_W-1:0] bcnt_r; // baud counter
  reg [3:0] bit_r; // bit/phase counter
  reg phase_r; // 0 = clock low half, 1 = high half
  reg [7:0] port_shift_reg_r; // shift register
  reg [7:0] port_data_buffer_r; // data buffer
  reg rx_enable_bit_r; // receive enable
  reg ack_value_bit_r; // master ack value
  reg slave_ack_status_r; // sampled slave ack
  reg [`I2CMR_NSTAT-1:0] stat_r; // sticky flags
  reg [`I2CMR_NSTAT-1:0] mask_r; // interrupt mask
  reg scl_lo_r; // clock driven low
  reg sda_lo_r; // data driven low
  // the two drive flags are copied into the pin flops
  // so every pin output comes straight from a register
  // the out values stay low: open drain only pulls down
  // release is done by raising the enable

  // apb strobes
  // an access completes at the edge where pready is high
  // every write and every read side effect keys off it
  // busy_shift marks address and receive shifting
  // a buffer write then is a collision
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire idle = (state_r == ST_IDLE);
  wire roll = (bcnt_r == {BAUD_W{1'b0}});
  wire busy_shift = (state_r == ST_RX) | (state_r == ST_ADDR);
  wire ctrl_wr = wr & hit(paddr, `I2CMR_OFF_CTRL);
  wire data_wr = wr & hit(paddr, `I2CMR_OFF_DATA);
  wire data_rd = rd & hit(paddr, `I2CMR_OFF_DATA);
  wire stat_rd = rd & hit(paddr, `I2CMR_OFF_STAT);
  wire mapped = hit(paddr, `I2CMR_OFF_CTRL) | hit(paddr, `I2CMR_OFF_DATA) |
                hit(paddr, `I2CMR_OFF_STAT) | hit(paddr, `I2CMR_OFF_MASK) |
                hit(paddr, `I2CMR_OFF_BAUD);

  // event pulses raised by the sequencer
  reg ev_evt, ev_bf, ev_ov, ev_write_collision_flag;

  // apb answer: one wait-free access phase, ready one cycle after setup
  // pready stands for exactly one cycle per transfer
  // pslverr rises with pready for an unmapped offset
  // read data is latched in the setup cycle
  // so it stands steady through the access phase
  // an unmapped read returns zero
  // a read of data or status has its side effect at access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        // read mux
        if (hit(paddr, `I2CMR_OFF_CTRL))
          prdata <= {26'h0000000, slave_ack_status_r, 1'b0, ack_value_bit_r,
                     1'b0, rx_enable_bit_r, 1'b0};
        else if (hit(paddr, `I2CMR_OFF_DATA))
          prdata <= {24'h000000, port_data_buffer_r};
        else if (hit(paddr, `I2CMR_OFF_STAT))
          prdata <= {28'h0000000, stat_r};
        else if (hit(paddr, `I2CMR_OFF_MASK))
          prdata <= {28'h0000000, mask_r};
        else if (hit(paddr, `I2CMR_OFF_BAUD))
          prdata <= {{(32-BAUD_W){1'b0}}, baud_r};
        else
          prdata <= 32'h00000000;
      end
    end
  end

  // mask and baud registers
  // plain storage, written at the access edge
  // a new baud value takes effect at the next reload
  // mask bits follow the status layout
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= {`I2CMR_NSTAT{1'b0}};
      baud_r <= `I2CMR_BAUD_RST;
    end else if (clk_en) begin
      if (wr & hit(paddr, `I2CMR_OFF_MASK))
        mask_r <= pwdata[`I2CMR_NSTAT-1:0];
      if (wr & hit(paddr, `I2CMR_OFF_BAUD))
        baud_r <= pwdata[BAUD_W-1:0];
    end
  end

  // sequencer: start, address, receive, ack, stop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      bcnt_r <= {BAUD_W{1'b0}};
      bit_r <= 4'h0;
      phase_r <= 1'b0;
      port_shift_reg_r <= 8'h00;
      port_data_buffer_r <= 8'h00;
      rx_enable_bit_r <= 1'b0;
      ack_value_bit_r <= 1'b0;
      slave_ack_status_r <= 1'b0;
      scl_lo_r <= 1'b0;
      sda_lo_r <= 1'b0;
      ev_evt <= 1'b0;
      ev_bf <= 1'b0;
      ev_ov <= 1'b0;
      ev_write_collision_flag <= 1'b0;
    end else if (clk_en) begin
      ev_evt <= 1'b0;
      ev_bf <= 1'b0;
      ev_ov <= 1'b0;
      ev_write_collision_flag <= 1'b0;
      if (ctrl_wr)
        ack_value_bit_r <= pwdata[`I2CMR_C_ACK_VALUE_BIT];
      // R8: buffer write collision
      if (data_wr & busy_shift)
        ev_write_collision_flag <= 1'b1;
      if (!idle)
        bcnt_r <= roll ? baud_r : bcnt_r - 1'b1;
      case (state_r)
        ST_IDLE, ST_HOLD: begin
          bcnt_r <= baud_r;
          phase_r <= 1'b0;
          bit_r <= 4'h0;
          if (ctrl_wr & pwdata[`I2CMR_C_SEN]) begin
            // start: data falls while clock high
            scl_lo_r <= 1'b0;
            state_r <= ST_START;
          end else if (ctrl_wr & pwdata[`I2CMR_C_RX_ENABLE_BIT]) begin
            // R2: taken in idle or hold
            rx_enable_bit_r <= 1'b1;
            sda_lo_r <= 1'b0;
            state_r <= ST_RX;
          end else if (ctrl_wr & pwdata[`I2CMR_C_ACK_SEQUENCE_START]) begin
            // R15: drive the chosen ack value
            sda_lo_r <= ~pwdata[`I2CMR_C_ACK_VALUE_BIT];
            state_r <= ST_ACK;
          end else if (ctrl_wr & pwdata[`I2CMR_C_PEN]) begin
            sda_lo_r <= 1'b1;
            state_r <= ST_STOP;
          end else if (data_wr) begin
            // R11: address transmission begins on buffer write
            port_shift_reg_r <= pwdata[7:0];
            sda_lo_r <= ~pwdata[7];
            state_r <= ST_ADDR;
          end
        end
        ST_START: if (roll) begin
          if (!sda_lo_r) begin
            sda_lo_r <= 1'b1;
          end else begin
            // R10: start done, event flag
            scl_lo_r <= 1'b1;
            ev_evt <= 1'b1;
            state_r <= ST_HOLD;
          end
        end
        ST_ADDR: if (roll) begin
          phase_r <= ~phase_r;
          scl_lo_r <= phase_r;
          if (phase_r && (bit_r == `I2CMR_NBITS)) begin
            // R12: slave ack taken late in high half
            slave_ack_status_r <= sda_in;
            // R13: end of ninth clock
            ev_evt <= 1'b1;
            sda_lo_r <= 1'b0;
            state_r <= ST_HOLD;
          end else if (phase_r) begin
            bit_r <= bit_r + 4'h1;
            port_shift_reg_r <= {port_shift_reg_r[6:0], 1'b0};
            // release data for ack after eighth bit
            sda_lo_r <= (bit_r == `I2CMR_NBITS - 4'h1) ? 1'b0 : ~port_shift_reg_r[6];
          end
        end
        ST_RX: if (roll) begin
          // R3: toggle clock, shift on rollover
          phase_r <= ~phase_r;
          scl_lo_r <= phase_r;
          if (phase_r) begin
            // R17: msb first, sampled late in high half
            port_shift_reg_r <= {port_shift_reg_r[6:0], sda_in};
            if (bit_r == `I2CMR_NBITS - 4'h1) begin
              // R4: eighth fall ends byte, clock held low
              rx_enable_bit_r <= 1'b0;
              port_data_buffer_r <= {port_shift_reg_r[6:0], sda_in};
              // R6: buffer-full on load
              ev_bf <= 1'b1;
              ev_evt <= 1'b1;
              // R7: overflow when still full
              ev_ov <= stat_r[`I2CMR_S_BF];
              // R5: on to hold, not back to idle
              state_r <= ST_HOLD;
            end else begin
              // more bits to come
              bit_r <= bit_r + 4'h1;
            end
          end
        end
        ST_ACK: if (roll) begin
          phase_r <= ~phase_r;
          scl_lo_r <= phase_r;
          if (phase_r) begin
            ev_evt <= 1'b1;
            sda_lo_r <= 1'b0;
            state_r <= ST_HOLD;
          end
        end
        ST_STOP: if (roll) begin
          if (scl_lo_r) begin
            scl_lo_r <= 1'b0;
          end else begin
            // stop: data rises while clock high
            sda_lo_r <= 1'b0;
            ev_evt <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // on overflow the new byte still loads the buffer
      // the older unread byte is lost
      // software learns of it from the overflow flag
      // a write collision leaves the buffer untouched
    end
  end

  // sticky status; a set beats a read-clear
  // a status read clears event, overflow and collision
  // an event in the same cycle as the read survives it
  // buffer-full follows the buffer, not the status read
  // it clears only when the buffer itself is read
  // a new byte in the same cycle keeps it set
  // the sequencer raises one-cycle event pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= {`I2CMR_NSTAT{1'b0}};
    end else if (clk_en) begin
      if (stat_rd) begin
        stat_r[`I2CMR_S_EVT] <= ev_evt;
        stat_r[`I2CMR_S_OV] <= ev_ov;
        stat_r[`I2CMR_S_WRITE_COLLISION_FLAG] <= ev_write_collision_flag;
      end else begin
        stat_r[`I2CMR_S_EVT] <= stat_r[`I2CMR_S_EVT] | ev_evt;
        stat_r[`I2CMR_S_OV] <= stat_r[`I2CMR_S_OV] | ev_ov;
        stat_r[`I2CMR_S_WRITE_COLLISION_FLAG] <= stat_r[`I2CMR_S_WRITE_COLLISION_FLAG] | ev_write_collision_flag;
      end
      // R6: buffer read clears buffer-full
      if (ev_bf)
        stat_r[`I2CMR_S_BF] <= 1'b1;
      else if (data_rd)
        stat_r[`I2CMR_S_BF] <= 1'b0;
    end
  end

  // pins and interrupt from flops
  // enables are low while a pin is pulled low
  // one cycle after the drive flags change
  // the pin never sees a glitch from the sequencer
  // irq is high while any unmasked flag is set
  // it trails the status register by one cycle
  // clock enable low freezes the pins as well
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      irq <= 1'b0;
    end else if (clk_en) begin
      scl_oe_n <= ~scl_lo_r;
      sda_oe_n <= ~sda_lo_r;
      irq <= |(stat_r & mask_r);
    end
  end
endmodule // i2cmr_master_rx

// >>> design/i2cmr_defines.vh
// Notes on behaviour
// R1: software sets receive enable to read byte
// R2: receive enable ignored unless port idle
// R3: baud rollover toggles clock, shifts data
// R4: eighth fall: clear enable, buffer, flags, hold
// R5: after byte, port returns idle; code goes to hold instead
// R6: buffer-full set on load, cleared by read
// R7: overflow when byte arrives, buffer full
// R8: buffer write while shifting sets collision
// R9: software starts with start enable, clears event
// R10: event flag set after start condition
// R11: buffer write sends eight address bits
// R12: slave acknowledge sampled into status bit
// R13: event flag at end of ninth clock
// R14: software picks ack value, starts ack
// R15: ack sequence clocks value, sets event
// R16: software repeats steps, ends with nack/stop
// R17: sample data while clock high, msb first
`ifndef I2CMR_DEFINES_VH
`define I2CMR_DEFINES_VH
// register byte offsets
`define I2CMR_OFF_CTRL 12'h000
`define I2CMR_OFF_DATA 12'h004
`define I2CMR_OFF_STAT 12'h008
`define I2CMR_OFF_MASK 12'h00C
`define I2CMR_OFF_BAUD 12'h010
// control register bits
`define I2CMR_C_SEN 0
`define I2CMR_C_RX_ENABLE_BIT 1
`define I2CMR_C_ACK_SEQUENCE_START 2
`define I2CMR_C_ACK_VALUE_BIT 3
`define I2CMR_C_PEN 4
`define I2CMR_C_SLAVE_ACK_STATUS 5
// status register bits
`define I2CMR_S_EVT 0
`define I2CMR_S_BF 1
`define I2CMR_S_OV 2
`define I2CMR_S_WRITE_COLLISION_FLAG 3
`define I2CMR_NSTAT 4
// baud reload reset value
`define I2CMR_BAUD_RST 8'h04
// bits per byte
`define I2CMR_NBITS 4'h8
`endif

// >>> testbench/i2cmr_master_rx_monitor.sv
module i2cmr_chk (
  // clock, reset
  input logic pclk,
  input logic presetn,
  // apb
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // pins, irq
  input logic scl_out,
  input logic sda_out,
  input logic scl_oe_n,
  input logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc; // access edge
  logic [3:0] mask_r; // mask mirror
  assign acc = psel && penable && pready;
  // follow mask writes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) mask_r <= 4'h0;
    else if (acc && pwrite && paddr == 12'h00C) mask_r <= pwdata[3:0];
  ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  unmapped_read_a: assert property (acc && !pwrite && paddr > 12'h010 |-> pslverr && prdata == 0)
    else $error("unmapped read");
  mapped_ok_a: assert property (acc && paddr < 12'h014 && paddr[1:0] == 0 |-> !pslverr)
    else $error("bad error");
  drive_low_a: assert property (!scl_out && !sda_out) else $error("pin drives high");
  clock_high_a: assert property ($rose(scl_oe_n) |-> scl_oe_n [*5])
    else $error("short high");
  clock_low_a: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*5])
    else $error("short low");
  irq_masked_a: assert property (irq |-> mask_r != 4'h0) else $error("irq unmasked");
  cover property ($rose(irq));
  cover property (acc && pslverr);
  cover property ($fell(scl_oe_n));
endmodule // i2cmr_chk

// >>> testbench/i2cmr_slave.sv
module i2cmr_slave (
  // bus wires
  input logic scl,
  input logic sda,
  // byte to return
  input logic [7:0] tx_byte,
  // data drive, high = released
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = -100; // clock falls since start
  int pos; // slot in data phase
  // start restarts count
  always @(negedge sda) if (scl) cnt = -1;
  // count clock falls
  always @(negedge scl) cnt = cnt + 1;
  assign pos = (cnt - 9) % 9;
  // ack low, then bytes msb first
  assign sda_rel = cnt == 8 ? 1'b0 : cnt >= 9 && pos < 8 ? tx_byte[7 - pos] : 1'b1;
endmodule // i2cmr_slave

// >>> testbench/i2cmr_master_rx_tb.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module i2cmr_master_rx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, irq, sda_rel, scl, sda;
  logic [7:0] tx_byte = 0;
  logic [64:0] notes[$]; // expected {err, mask, value}
  logic [64:0] nt;
  int num_errors = 0, check_count = 0, cyc = 0;
  bit [31:0] seed = 32'h2E5EECB5;
  // open-drain wires, pulled up
  assign scl = scl_oe_n | scl_out;
  assign sda = (sda_oe_n | sda_out) & sda_rel;
  i2cmr_master_rx i_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda),
    .sda_out, .sda_oe_n, .irq);
  i2cmr_slave i_slv (.scl, .sda, .tx_byte, .sda_rel);
  initial forever #50 pclk = ~pclk;
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one apb transfer; a read leaves a note
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d, logic [31:0] m = 0, bit e = 0);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) notes.push_back({e, m, d});
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_irq();
    do @(posedge pclk); while (irq !== 1'b1);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // compare each read with the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
    if (psel && penable && pready && !pwrite) begin
      nt = notes.pop_front();
      `CHK({pslverr, prdata & nt[63:32]}, {nt[64], nt[31:0]})
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h00C, 0, 32'hF);
    apb(0, 12'h010, 4, 32'hFF);
    apb(1, 12'h00C, 1); // events only
    apb(1, 12'h000, 1);
    wait_irq();
    apb(0, 12'h008, 1, 32'hF);
    apb(1, 12'h004, 8'hA1);
    wait_irq();
    apb(0, 12'h008, 1, 32'hF);
    apb(0, 12'h000, 0, 32'h20);
    for (int n = 0; n < 3; n++) begin
      tx_byte <= 8'(rnd());
      apb(1, 12'h000, 2);
      apb(1, 12'h000, 1);
      if (n == 0) apb(1, 12'h004, 8'(rnd()));
      wait_irq();
      apb(0, 12'h008, n == 0 ? 32'hB : n == 2 ? 32'h7 : 32'h3, 32'hF);
      apb(0, 12'h000, 0, 32'h2);
      if (n != 1) apb(0, 12'h004, tx_byte, 32'hFF);
      apb(0, 12'h008, n == 1 ? 2 : 0, 32'h2);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(1, 12'h000, n == 2 ? 32'hC : 32'h4);
      wait_irq();
      apb(0, 12'h008, 1, 32'h1);
    end
    apb(1, 12'h000, 16);
    apb(0, 12'h020, 0, 32'hFFFFFFFF, 1);
    wrap_up();
  end
endmodule // i2cmr_master_rx_tb
bind i2cmr_master_rx i2cmr_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .scl_out, .sda_out, .scl_oe_n, .irq);
